// >>> include/eec_map.svh
`ifndef EEC_MAP_SVH
`define EEC_MAP_SVH
// Overview of operation
// - Start is data falling while clock high; master starts every transfer with it.
// - Stop is data rising while clock high; it ends the communication.
// - After a read answered with no_acknowledge, master may stop; device returns to standby.
// - Transmitter releases data after eight bits; receiver pulls low in ninth pulse.
// - Master holds data steady across rising clock, changes it only while clock low.
// - After start, master sends the select byte most significant bit first.
// - Location address is 16 bits in two bytes, high byte first.
// - Only the master begins transfers and always drives the serial clock.
// - Random read: write select and address, repeated start, read select, byte returned.
// - Sequential read returns one or more bytes; reads ignore write protect.
// - A page write carries at most 128 bytes within one row of b15..b7.
`define EEC_CLK_NS 100
`define EEC_QTR_NS 300
`define EEC_QTR_CYC ((`EEC_QTR_NS + `EEC_CLK_NS - 1) / `EEC_CLK_NS)
`define EEC_REG_CMD 8'h00
`define EEC_REG_TXD 8'h04
`define EEC_REG_RXD 8'h08
`define EEC_REG_STAT 8'h0c
`define EEC_REG_ADDR 8'h10
`define EEC_REG_PINS 8'h14
`define EEC_CMD_OP_MSB 2
`define EEC_CMD_NACK 4
`define EEC_CMD_IDPG 5
`define EEC_CMD_RD 6
`define EEC_ST_BUSY 0
`define EEC_ST_NACK 1
`define EEC_ST_PGOVR 2
`define EEC_ST_NEEDSTOP 3
`define EEC_PINS_WP 3
`define EEC_PINS_RST 4'h0
`define EEC_ARRAY_ID 4'h5
`define EEC_IDPG_ID 4'h6
`define EEC_PAGE_BYTES 8'h80
`endif

// >>> include/eec_pkg.sv
package eec_pkg;
  typedef enum logic [2:0] {
    EEC_OP_NONE = 3'h0,
    EEC_OP_START = 3'h1,
    EEC_OP_STOP = 3'h2,
    EEC_OP_WRITE = 3'h3,
    EEC_OP_READ = 3'h4,
    EEC_OP_SELECT = 3'h5,
    EEC_OP_ADDRESS = 3'h6
  } eec_op_type;
  typedef enum logic [1:0] {
    EEC_B_NONE = 2'h0,
    EEC_B_START = 2'h1,
    EEC_B_STOP = 2'h2,
    EEC_B_BIT = 2'h3
  } eec_bop_type;
  typedef enum logic [3:0] {
    EEC_S_IDLE = 4'h1,
    EEC_S_COND = 4'h2,
    EEC_S_DATA = 4'h4,
    EEC_S_ACK = 4'h8
  } eec_state_type;
  typedef struct packed {
    eec_bop_type op;
    logic tx;
  } eec_breq_type;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } eec_wr_type;
endpackage

// >>> hw/eec_ahb_slave.sv
module eec_ahb_slave (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register side
  output eec_pkg::eec_wr_type wr,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_val
);
  import eec_pkg::*;
  logic wen_q;
  logic [7:0] waddr_q;
  logic [31:0] hrdata_q;
  // only word accesses store; narrower writes are dropped, reads still answer
  wire phase_ok = hsel && htrans[1] && hready;
  wire take_wr = phase_ok && hwrite && (hsize == 3'h2);
  wire take_rd = phase_ok && !hwrite;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign rd_addr = haddr[7:0];
  assign wr = '{en: wen_q, addr: waddr_q, data: hwdata};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wen_q <= 1'b0;
      waddr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wen_q <= take_wr;
      waddr_q <= haddr[7:0];
      if (take_rd) begin
        hrdata_q <= rd_val;
      end
    end
  end
endmodule

// >>> hw/eec_bit_engine.sv
`include "eec_map.svh"
module eec_bit_engine (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bit requests
  input wire eec_pkg::eec_breq_type breq,
  output logic ready,
  output logic done,
  output logic rx_bit,
  // serial pins
  output logic scl_out,
  input wire logic sda_in,
  output logic sda_oe
);
  import eec_pkg::*;
  localparam logic [3:0] QTR_LAST = 4'(`EEC_QTR_CYC - 1);
  eec_bop_type op_q;
  logic scl_q, oe_q, s1_q, s2_q, rx_q, done_q;
  logic [3:0] qcnt_q;
  logic [1:0] ph_q;
  wire busy = op_q != EEC_B_NONE;
  wire accept = !busy && (breq.op != EEC_B_NONE);
  wire tick = busy && (qcnt_q == QTR_LAST);
  wire drive_first = (breq.op == EEC_B_STOP) || ((breq.op == EEC_B_BIT) && !breq.tx);
  assign ready = !busy;
  assign done = done_q;
  assign rx_bit = rx_q;
  assign scl_out = scl_q;
  assign sda_oe = oe_q;
  // data pin comes from another domain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= sda_in;
      s2_q <= s1_q;
    end
  end
  // four quarters per request; clock idles high after a stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_q <= EEC_B_NONE;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      rx_q <= 1'b1;
      done_q <= 1'b0;
      qcnt_q <= 4'h0;
      ph_q <= 2'h0;
    end else begin
      done_q <= tick && (ph_q == 2'h3);
      if (accept) begin
        op_q <= breq.op;
        qcnt_q <= 4'h0;
        ph_q <= 2'h0;
        oe_q <= drive_first;
      end else if (tick) begin
        qcnt_q <= 4'h0;
        ph_q <= ph_q + 2'h1;
        case (ph_q)
          2'h0: scl_q <= 1'b1;
          2'h1: begin
            if (op_q == EEC_B_START) begin
              oe_q <= 1'b1;
            end else if (op_q == EEC_B_STOP) begin
              oe_q <= 1'b0;
            end
          end
          2'h2: begin
            if (op_q != EEC_B_STOP) begin
              scl_q <= 1'b0;
            end
            // sampled late in the high time, well past the sync delay
            if (op_q == EEC_B_BIT) begin
              rx_q <= s2_q;
            end
          end
          default: op_q <= EEC_B_NONE;
        endcase
      end else if (busy) begin
        qcnt_q <= qcnt_q + 4'h1;
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_scl_hold;
    scl_q [*3] ##1 !scl_q;
  endsequence
  property p_start_shape;
    ($rose(oe_q) && (op_q == EEC_B_START)) |-> s_scl_hold;
  endproperty
  a_start_shape: assert property (p_start_shape) else $error("start not formed under high clock");
  property p_stop_shape;
    ($fell(oe_q) && (op_q == EEC_B_STOP)) |-> scl_q [*2];
  endproperty
  a_stop_shape: assert property (p_stop_shape) else $error("stop not formed under high clock");
  property p_sda_hold;
    ((op_q == EEC_B_BIT) && scl_q) |-> $stable(oe_q);
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("data moved while clock high");
  property p_done_time;
    accept |-> ##13 done_q;
  endproperty
  a_done_time: assert property (p_done_time) else $error("bit request did not finish in time");
endmodule

// >>> hw/eec_host.sv
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`include "eec_map.svh"
module eec_host (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial bus
  output logic scl_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // device straps
  output logic chip_sel_in_0,
  output logic chip_sel_in_1,
  output logic chip_sel_in_2,
  output logic write_protect_in
);
  import eec_pkg::*;

  eec_wr_type wr;
  logic [7:0] rd_addr;
  logic [31:0] rd_val;
  eec_breq_type breq;
  logic eng_ready, eng_done, rx_bit;

  eec_state_type st_q;
  eec_op_type op_q;
  logic [7:0] sh_q, lo_q, rx_q, tx_q, cnt_q;
  logic [15:0] addr_q;
  logic [3:0] pins_q;
  logic [2:0] bitn_q;
  logic rd_q, nsend_q, second_q, nack_q, pgovr_q, needstop_q;
  logic [31:0] stat_w;

  eec_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_val(rd_val)
  );

  eec_bit_engine u_bits (
    .hclk(hclk),
    .hresetn(hresetn),
    .breq(breq),
    .ready(eng_ready),
    .done(eng_done),
    .rx_bit(rx_bit),
    .scl_out(scl_out),
    .sda_in(sda_in),
    .sda_oe(sda_oe)
  );

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign chip_sel_in_0 = pins_q[0];
  assign chip_sel_in_1 = pins_q[1];
  assign chip_sel_in_2 = pins_q[2];
  assign write_protect_in = pins_q[`EEC_PINS_WP];

  // command decode
  wire cmd_wr = wr.en && (wr.addr == `EEC_REG_CMD);
  wire [2:0] cmd_raw = wr.data[`EEC_CMD_OP_MSB:0];
  wire eec_op_type cmd_op = eec_op_type'(cmd_raw);
  wire op_known = (cmd_raw != 3'h0) && (cmd_raw != 3'h7);
  // no further read once no_acknowledge went out; a stop or start must come first
  wire read_blocked = (cmd_op == EEC_OP_READ) && needstop_q;
  wire idle = st_q == EEC_S_IDLE;
  wire go = cmd_wr && idle && op_known && !read_blocked;
  wire is_cond = (cmd_op == EEC_OP_START) || (cmd_op == EEC_OP_STOP);
  wire [3:0] type_id = wr.data[`EEC_CMD_IDPG] ? `EEC_IDPG_ID : `EEC_ARRAY_ID;
  // select byte: identifier, straps in b3..b1, direction in b0
  wire [7:0] sel_byte = {type_id, pins_q[2:0], wr.data[`EEC_CMD_RD]};
  wire [7:0] load_byte = (cmd_op == EEC_OP_SELECT) ? sel_byte :
                         (cmd_op == EEC_OP_ADDRESS) ? addr_q[15:8] : tx_q;
  // reads never look at the write protect strap
  wire [7:0] sh_next = {sh_q[6:0], rd_q ? rx_bit : 1'b0};
  wire [7:0] row_fill = {1'b0, addr_q[6:0]} + cnt_q;
  wire row_over = row_fill >= `EEC_PAGE_BYTES;

  // bit requests, withheld in the cycle a bit completes
  wire eec_bop_type cond_op = (op_q == EEC_OP_STOP) ? EEC_B_STOP : EEC_B_START;
  wire eec_bop_type req_op = (idle || eng_done) ? EEC_B_NONE :
                             (st_q == EEC_S_COND) ? cond_op : EEC_B_BIT;
  wire data_tx = rd_q | sh_q[7];
  wire ack_tx = rd_q ? nsend_q : 1'b1;
  wire req_tx = (st_q == EEC_S_ACK) ? ack_tx : data_tx;
  assign breq = '{op: req_op, tx: req_tx};

  // register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_q <= 8'h00;
      addr_q <= 16'h0000;
      pins_q <= `EEC_PINS_RST;
    end else if (wr.en) begin
      if (wr.addr == `EEC_REG_TXD) begin
        tx_q <= wr.data[7:0];
      end
      if (wr.addr == `EEC_REG_ADDR) begin
        addr_q <= wr.data[15:0];
      end
      if (wr.addr == `EEC_REG_PINS) begin
        pins_q <= wr.data[3:0];
      end
    end
  end

  // byte sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= EEC_S_IDLE;
      op_q <= EEC_OP_NONE;
      sh_q <= 8'h00;
      lo_q <= 8'h00;
      bitn_q <= 3'h0;
      rd_q <= 1'b0;
      nsend_q <= 1'b0;
      second_q <= 1'b0;
    end else if (go) begin
      op_q <= cmd_op;
      st_q <= is_cond ? EEC_S_COND : EEC_S_DATA;
      sh_q <= load_byte;
      lo_q <= addr_q[7:0];
      bitn_q <= 3'h0;
      rd_q <= cmd_op == EEC_OP_READ;
      nsend_q <= wr.data[`EEC_CMD_NACK];
      second_q <= cmd_op == EEC_OP_ADDRESS;
    end else if (eng_done) begin
      case (st_q)
        EEC_S_DATA: begin
          sh_q <= sh_next;
          bitn_q <= bitn_q + 3'h1;
          if (bitn_q == 3'h7) begin
            st_q <= EEC_S_ACK;
          end
        end
        EEC_S_ACK: begin
          if (second_q) begin
            sh_q <= lo_q;
            second_q <= 1'b0;
            bitn_q <= 3'h0;
            st_q <= EEC_S_DATA;
          end else begin
            st_q <= EEC_S_IDLE;
          end
        end
        default: st_q <= EEC_S_IDLE;
      endcase
    end
  end

  // status bits; the events that write them never fall in one cycle, so no set/clear race
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_q <= 8'h00;
      nack_q <= 1'b0;
      pgovr_q <= 1'b0;
      needstop_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (go && (cmd_op == EEC_OP_ADDRESS)) begin
      cnt_q <= 8'h00;
      pgovr_q <= 1'b0;
    end else if (eng_done && (st_q == EEC_S_COND)) begin
      needstop_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (eng_done && (st_q == EEC_S_ACK)) begin
      if (rd_q) begin
        rx_q <= sh_q;
        needstop_q <= nsend_q;
      end else begin
        nack_q <= rx_bit;
      end
      if (op_q == EEC_OP_WRITE) begin
        // counter saturates so the row sum cannot wrap
        if (row_over) begin
          pgovr_q <= 1'b1;
        end
        if (cnt_q != `EEC_PAGE_BYTES) begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end

  // read mux
  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[`EEC_ST_BUSY] = !idle;
    stat_w[`EEC_ST_NACK] = nack_q;
    stat_w[`EEC_ST_PGOVR] = pgovr_q;
    stat_w[`EEC_ST_NEEDSTOP] = needstop_q;
  end
  wire sel_cmd = rd_addr == `EEC_REG_CMD;
  wire sel_txd = rd_addr == `EEC_REG_TXD;
  wire sel_rxd = rd_addr == `EEC_REG_RXD;
  wire sel_stat = rd_addr == `EEC_REG_STAT;
  wire sel_addr = rd_addr == `EEC_REG_ADDR;
  wire sel_pins = rd_addr == `EEC_REG_PINS;
  assign rd_val = sel_cmd ? {29'h0, op_q} :
                  sel_txd ? {24'h0, tx_q} :
                  sel_rxd ? {24'h0, rx_q} :
                  sel_stat ? stat_w :
                  sel_addr ? {16'h0, addr_q} :
                  sel_pins ? {28'h0, pins_q} : 32'h0000_0000;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_addr_go;
    go && (cmd_op == EEC_OP_ADDRESS);
  endsequence
  sequence s_second_due;
    (st_q == EEC_S_ACK) && second_q && eng_done;
  endsequence
  property p_busy_after_go;
    go |=> !idle ##1 (breq.op != EEC_B_NONE);
  endproperty
  a_busy_after_go: assert property (p_busy_after_go) else $error("command did not start");
  property p_select_byte;
    (go && (cmd_op == EEC_OP_SELECT)) |=> (sh_q == $past(sel_byte)) && (st_q == EEC_S_DATA);
  endproperty
  a_select_byte: assert property (p_select_byte) else $error("select byte wrongly composed");
  property p_addr_order;
    s_addr_go |=> (sh_q == addr_q[15:8]) && second_q;
  endproperty
  a_addr_order: assert property (p_addr_order) else $error("high address byte not first");
  property p_addr_low;
    s_second_due |=> (sh_q == lo_q) && (st_q == EEC_S_DATA) && !second_q;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("low address byte not second");
  property p_ack_slot;
    ((st_q == EEC_S_ACK) && !eng_ready) |-> (sda_oe == (rd_q && !nsend_q));
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("wrong level in acknowledge slot");
  property p_read_refused;
    (cmd_wr && idle && needstop_q && (cmd_op == EEC_OP_READ)) |=> idle;
  endproperty
  a_read_refused: assert property (p_read_refused) else $error("read ran after no_acknowledge");
endmodule

// >>> tb/eec_dev_model.sv
`include "eec_map.svh"
module eec_dev_model #(
  parameter int WT_NS = 30000
) (
  // power and straps
  input wire logic por_n,
  input wire logic chip_sel_in_0,
  input wire logic chip_sel_in_1,
  input wire logic chip_sel_in_2,
  input wire logic write_protect_in,
  // serial bus
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] idm [0:127];
  logic [7:0] sh;
  logic [15:0] ptr;
  logic idp, busy, wrote;
  // 0 standby, 1 select, 2/3 address, 4 write, 5 read, 6 wait stop, 7 read select acked
  int bitn, ph;
  wire logic [7:0] rdb = idp ? idm[ptr[6:0]] : mem[ptr];
  initial begin
    sda_oe = 0;
    ph = 0;
    busy = 0;
    wrote = 0;
    idp = 0;
    ptr = 0;
    bitn = 0;
  end
  always @(negedge por_n) begin
    ph = 0;
    sda_oe = 0;
  end
  always @(posedge por_n) begin
    ph = 0;
    busy = 0;
  end
  // model edges are ideal, so no glitch filter here
  always @(negedge sda) if (scl && por_n && !busy) begin
    ph = 1;
    bitn = 0;
    wrote = 0;
  end
  always @(posedge sda) if (scl && ph != 0) begin
    ph = 0;
    if (wrote) begin
      wrote = 0;
      busy = 1;
      #WT_NS busy = 0;
    end
  end
  always @(posedge scl) if (por_n && ph != 0) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
      bitn++;
    end else begin
      bitn = 0;
      if (ph == 7) ph = 5;
      else if (ph == 5 && sda) ph = 6;
      else if (ph == 5) ptr++;
    end
  end
  // drives only while clock low, so no false start or stop is formed
  always @(negedge scl) if (por_n && ph != 0) begin
    sda_oe = 0;
    if (bitn == 8 && ph == 1 && sh[3:1] == {chip_sel_in_2, chip_sel_in_1, chip_sel_in_0} &&
        (sh[7:4] == `EEC_ARRAY_ID || sh[7:4] == `EEC_IDPG_ID)) begin
      idp = sh[7:4] == `EEC_IDPG_ID;
      ph = sh[0] ? 7 : 2;
      sda_oe = 1;
    end else if (bitn == 8 && ph == 1) ph = 0;
    else if (bitn == 8 && (ph == 2 || ph == 3)) begin
      ptr = ph == 2 ? {sh, ptr[7:0]} : {ptr[15:8], sh};
      ph++;
      sda_oe = 1;
    end else if (bitn == 8 && ph == 4 && !write_protect_in) begin
      if (idp) idm[ptr[6:0]] = sh;
      else mem[ptr] = sh;
      ptr[6:0] = ptr[6:0] + 7'h01;
      wrote = 1;
      sda_oe = 1;
    end else if (ph == 5 && bitn < 8) sda_oe = !rdb[7 - bitn];
  end
endmodule

// >>> tb/eec_host_bench.sv
`include "eec_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module eec_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import eec_pkg::*;
  localparam logic [31:0] START = 32'h1, STOP = 32'h2, WR = 32'h3, RD = 32'h4, SEL = 32'h5, ADR = 32'h6;
  localparam logic [31:0] NAK = 32'h10, IDP = 32'h20, RDB = 32'h40;
  logic hclk, hresetn, hsel, hwrite, por_n, hready, hresp, scl_out, sda_out, sda_oe, dev_oe;
  logic cs0, cs1, cs2, write_protect_in;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int error_cnt, comparisons, i, tries;
  // open-drain data line with pull-up
  wire logic sda = !((sda_oe && !sda_out) || dev_oe);
  eec_host u_eec_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .scl_out(scl_out), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_sel_in_0(cs0), .chip_sel_in_1(cs1), .chip_sel_in_2(cs2), .write_protect_in(write_protect_in));
  eec_dev_model u_eec_dev_model (.por_n(por_n), .chip_sel_in_0(cs0), .chip_sel_in_1(cs1),
    .chip_sel_in_2(cs2), .write_protect_in(write_protect_in), .scl(scl_out), .sda(sda), .sda_oe(dev_oe));
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic limit(input int n, input int m);
    if (n >= m) begin
      error_cnt++;
      $display("[ERR] %0t wait limit", $time);
      results();
    end
  endtask
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    limit(n, 50);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait();
    rd = hrdata;
  endtask
  task automatic op(input logic [31:0] c);
    int n;
    ahb(1'b1, `EEC_REG_CMD, c, d);
    n = 0;
    do begin
      ahb(1'b0, `EEC_REG_STAT, 32'h0, d);
      n++;
    end while (d[`EEC_ST_BUSY] !== 1'b0 && n < 300);
    limit(n, 300);
  endtask
  task automatic st(input int b, input logic e);
    ahb(1'b0, `EEC_REG_STAT, 32'h0, d);
    `CHK(d[b], e)
  endtask
  task automatic head(input logic [31:0] idp, input logic [15:0] a);
    op(START);
    op(SEL | idp);
    st(`EEC_ST_NACK, 1'b0);
    ahb(1'b1, `EEC_REG_ADDR, {16'h0, a}, d);
    op(ADR);
    st(`EEC_ST_NACK, 1'b0);
  endtask
  task automatic wbyte(input logic [7:0] v);
    ahb(1'b1, `EEC_REG_TXD, {24'h0, v}, d);
    op(WR);
  endtask
  task automatic rd2(input logic [31:0] idp, input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    head(idp, a);
    op(START);
    op(SEL | idp | RDB);
    op(RD);
    ahb(1'b0, `EEC_REG_RXD, 32'h0, d);
    `CHK(d[7:0], e0)
    op(RD | NAK);
    ahb(1'b0, `EEC_REG_RXD, 32'h0, d);
    `CHK(d[7:0], e1)
    ahb(1'b1, `EEC_REG_CMD, RD, d);
    st(`EEC_ST_BUSY, 1'b0);
    op(STOP);
    st(`EEC_ST_NEEDSTOP, 1'b0);
  endtask
  // ack polling: the device stays deaf until its write cycle ends
  task automatic poll(output int t);
    logic [31:0] s;
    t = 0;
    do begin
      op(START);
      op(SEL);
      ahb(1'b0, `EEC_REG_STAT, 32'h0, s);
      op(STOP);
      t++;
    end while (s[`EEC_ST_NACK] !== 1'b0 && t < 20);
    if (s[`EEC_ST_NACK] !== 1'b0) limit(1, 1);
  endtask
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    por_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (10) @(posedge hclk);
    `CHK(scl_out, 1'b1)
    `CHK(sda_oe, 1'b0)
    `CHK(hrdata, 32'h0)
    `CHK(hresp, 1'b0)
    hresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, `EEC_REG_PINS, 32'h5, d);
    ahb(1'b0, `EEC_REG_PINS, 32'h0, d);
    `CHK(d[3:0], 4'h5)
    `CHK({write_protect_in, cs2, cs1, cs0}, 4'h5)
    ahb(1'b1, 8'h20, 32'hffff_ffff, d);
    ahb(1'b0, 8'h20, 32'h0, d);
    `CHK(d, 32'h0)
    ahb(1'b1, `EEC_REG_CMD, 32'h7, d);
    ahb(1'b0, `EEC_REG_CMD, 32'h0, d);
    `CHK(d[2:0], 3'h0)
    ahb(1'b0, `EEC_REG_STAT, 32'h0, d);
    `CHK(d[`EEC_ST_BUSY], 1'b0)
    hsize <= 3'h0;
    ahb(1'b1, `EEC_REG_TXD, 32'h99, d);
    hsize <= 3'h2;
    ahb(1'b0, `EEC_REG_TXD, 32'h0, d);
    `CHK(d[7:0], 8'h00)
    for (i = 0; i < 2; i++) begin
      head(i ? IDP : 32'h0, 16'h1234);
      wbyte(8'ha5);
      st(`EEC_ST_NACK, 1'b0);
      wbyte(8'h3c);
      op(STOP);
      poll(tries);
      `CHK(tries > 1, 1'b1)
      rd2(i ? IDP : 32'h0, 16'h1234, 8'ha5, 8'h3c);
    end
    // reads must not care about the protect strap
    ahb(1'b1, `EEC_REG_PINS, 32'hd, d);
    head(32'h0, 16'h1234);
    wbyte(8'hff);
    st(`EEC_ST_NACK, 1'b1);
    op(STOP);
    rd2(32'h0, 16'h1234, 8'ha5, 8'h3c);
    ahb(1'b1, `EEC_REG_PINS, 32'h5, d);
    head(32'h0, 16'h007f);
    wbyte(8'h11);
    st(`EEC_ST_PGOVR, 1'b0);
    wbyte(8'h22);
    st(`EEC_ST_PGOVR, 1'b1);
    op(STOP);
    poll(tries);
    por_n <= 1'b0;
    op(START);
    op(SEL);
    st(`EEC_ST_NACK, 1'b1);
    op(STOP);
    por_n <= 1'b1;
    op(START);
    op(SEL);
    st(`EEC_ST_NACK, 1'b0);
    op(STOP);
    ahb(1'b0, `EEC_REG_CMD, 32'h0, d);
    `CHK(d[2:0], 3'h2)
    results();
  end
endmodule
